// ---- design/tap_defs.vh ----
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH

// tap controller states, binary coded
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHIFT_DR 4'h4
`define ST_EXIT1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EXIT2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'hA
`define ST_SHIFT_IR 4'hB
`define ST_EXIT1_IR 4'hC
`define ST_PAUSE_IR 4'hD
`define ST_EXIT2_IR 4'hE
`define ST_UPD_IR 4'hF
`define ST_W 4

// instruction register
`define IR_W 4
`define IR_CAPTURE 4'h1
`define OP_EXTEST 4'h0
`define OP_SAMPLE 4'h1
`define OP_IDCODE 4'h2
`define OP_HIGHZ 4'h3
`define OP_BYPASS 4'hF

// data register selection codes
`define SEL_BYPASS 2'h0
`define SEL_BOUNDARY 2'h1
`define SEL_IDENT 2'h2
`define SEL_W 2

// identification word
`define ID_W 32
`define ID_VER_W 4
`define ID_PART_W 16
`define ID_MFR_W 11
`define ID_MARK 1'h1

// boundary chain: input cells first, then output cells
`define N_PAD_IN 8
`define N_PAD_OUT 8
`define BSR_LEN 16

`endif

// ---- design/boundary_chain.v ----
`timescale 1ns/10ps
`default_nettype none
`include "tap_defs.vh"

// shift, capture and update stages of the boundary-scan register
module boundary_chain (
  input wire clock,
  input wire rst_n,
  input wire capture,
  input wire shift,
  input wire update,
  input wire serial_in,
  input wire [`BSR_LEN-1:0] parallel_in,
  output wire serial_out,
  output reg [`BSR_LEN-1:0] update_r
);

  reg [`BSR_LEN-1:0] shift_r;

  assign serial_out = shift_r[0];

  // capture has priority over shift; both only fire on a tck rise
  always @(posedge clock) begin
    if (!rst_n) begin
      shift_r <= {`BSR_LEN{1'b0}};
    end else if (capture) begin
      shift_r <= parallel_in;
    end else if (shift) begin
      shift_r <= {serial_in, shift_r[`BSR_LEN-1:1]};
    end
  end

  // update stage holds preloaded values steady while shifting goes on
  always @(posedge clock) begin
    if (!rst_n) begin
      update_r <= {`BSR_LEN{1'b0}};
    end else if (update) begin
      update_r <= shift_r;
    end
  end

endmodule
`default_nettype wire

// ---- design/boundary_scan_tap.v ----
// Behaviour
// - five tck rises with tms high reach the reset state from anywhere
// - no automatic tap reset at power-up; trst_n or tms resets it
// - state changes only on tck rise, steered by sampled tms
// - in reset state all test logic is idle, fifo runs normally
// - capture-ir loads fixed pattern ending in binary 01
// - shift-ir puts instruction shifter between tdi and tdo
// - update-ir latches new instruction on falling tck
// - pause-ir holds instruction shifter contents unchanged
// - capture-dr loads selected data register; dr path mirrors ir path
// - instruction register four bits, lsb nearest tdo
// - decode 0 extest, 1 sample, 2 idcode, 3 highz, f bypass
// - data registers parallel between shared tdi and tdo
// - bypass is one stage, captures zero, never disturbs device
// - 32-bit read-only identification register shifted under idcode
// - id layout version, part, manufacturer, constant one in bit 0
// - idcode keeps device functional, selected right after tap reset
// - extest drives pad outputs from cells, captures pad inputs
// - sample keeps normal operation while boundary cells sample pins
// - tap logic overrides fifo operation on conflict
// - highz disables every output and selects bypass
`timescale 1ns/10ps
`default_nettype none
`include "tap_defs.vh"

module boundary_scan_tap #(
  // identity fields: arbitrary neutral values
  parameter [`ID_VER_W-1:0] ID_VERSION = 4'h1,
  parameter [`ID_PART_W-1:0] ID_PART = 16'h5A5A,
  parameter [`ID_MFR_W-1:0] ID_MFR = 11'h2AA
) (
  input wire clock,
  input wire rst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo,
  output reg tdo_oe,
  input wire [`N_PAD_IN-1:0] pad_in,
  output wire [`N_PAD_IN-1:0] core_in,
  input wire [`N_PAD_OUT-1:0] core_out,
  input wire core_oe,
  output reg [`N_PAD_OUT-1:0] pad_out,
  output reg [`N_PAD_OUT-1:0] pad_oe,
  output reg fifo_hold,
  output reg tap_in_reset,
  output reg [`IR_W-1:0] active_instruction
);

  // pin synchronisers, first stage feeds only the second
  reg tck_m_r;
  reg tck_s_r;
  reg tck_d_r;
  reg tms_m_r;
  reg tms_s_r;
  reg tdi_m_r;
  reg tdi_s_r;
  reg trst_m_r;
  reg trst_s_r;
  reg [`N_PAD_IN-1:0] pad_m_r;
  reg [`N_PAD_IN-1:0] pad_s_r;

  // tap state and shift stages
  reg [`ST_W-1:0] state_r;
  reg [`ST_W-1:0] state_nxt;
  reg [`IR_W-1:0] ir_shift_r;
  reg bypass_r;
  reg [`ID_W-1:0] id_shift_r;
  reg tdo_nxt;

  // edges and decoded controls
  wire tck_rise;
  wire tck_fall;
  wire [`SEL_W-1:0] dr_sel;
  wire [`ID_W-1:0] id_word;
  wire bsr_capture;
  wire bsr_shift;
  wire bsr_update;
  wire bsr_so;
  wire [`BSR_LEN-1:0] bsr_par;
  wire [`BSR_LEN-1:0] bsr_upd;
  wire drive_test;
  wire force_off;

  // next tap state from current state and sampled tms
  // codes outside the graph fall back to the reset state
  function [`ST_W-1:0] tap_next;
    input [`ST_W-1:0] st;
    input m;
    begin
      case (st)
        `ST_RESET: tap_next = m ? `ST_RESET : `ST_IDLE;
        `ST_IDLE: tap_next = m ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_DR: tap_next = m ? `ST_SEL_IR : `ST_CAP_DR;
        `ST_CAP_DR: tap_next = m ? `ST_EXIT1_DR : `ST_SHIFT_DR;
        `ST_SHIFT_DR: tap_next = m ? `ST_EXIT1_DR : `ST_SHIFT_DR;
        `ST_EXIT1_DR: tap_next = m ? `ST_UPD_DR : `ST_PAUSE_DR;
        `ST_PAUSE_DR: tap_next = m ? `ST_EXIT2_DR : `ST_PAUSE_DR;
        `ST_EXIT2_DR: tap_next = m ? `ST_UPD_DR : `ST_SHIFT_DR;
        `ST_UPD_DR: tap_next = m ? `ST_SEL_DR : `ST_IDLE;
        `ST_SEL_IR: tap_next = m ? `ST_RESET : `ST_CAP_IR;
        `ST_CAP_IR: tap_next = m ? `ST_EXIT1_IR : `ST_SHIFT_IR;
        `ST_SHIFT_IR: tap_next = m ? `ST_EXIT1_IR : `ST_SHIFT_IR;
        `ST_EXIT1_IR: tap_next = m ? `ST_UPD_IR : `ST_PAUSE_IR;
        `ST_PAUSE_IR: tap_next = m ? `ST_EXIT2_IR : `ST_PAUSE_IR;
        `ST_EXIT2_IR: tap_next = m ? `ST_UPD_IR : `ST_SHIFT_IR;
        `ST_UPD_IR: tap_next = m ? `ST_SEL_DR : `ST_IDLE;
        default: tap_next = `ST_RESET;
      endcase
    end
  endfunction

  // instruction to data register; used for capture, shift and tdo
  // highz shares the bypass stage so tdo still has a one-bit path
  function [`SEL_W-1:0] dr_decode;
    input [`IR_W-1:0] op;
    begin
      case (op)
        `OP_EXTEST: dr_decode = `SEL_BOUNDARY;
        `OP_SAMPLE: dr_decode = `SEL_BOUNDARY;
        `OP_IDCODE: dr_decode = `SEL_IDENT;
        `OP_HIGHZ: dr_decode = `SEL_BYPASS;
        `OP_BYPASS: dr_decode = `SEL_BYPASS;
        default: dr_decode = `SEL_BYPASS;
      endcase
    end
  endfunction

  // two flops on every pin before any logic looks at it
  // tck pulses under one clock high or low may be lost here
  always @(posedge clock) begin
    if (!rst_n) begin
      tck_m_r <= 1'b0;
      tck_s_r <= 1'b0;
      tck_d_r <= 1'b0;
      tms_m_r <= 1'b1;
      tms_s_r <= 1'b1;
      tdi_m_r <= 1'b0;
      tdi_s_r <= 1'b0;
      trst_m_r <= 1'b1;
      trst_s_r <= 1'b1;
      pad_m_r <= {`N_PAD_IN{1'b0}};
      pad_s_r <= {`N_PAD_IN{1'b0}};
    end else begin
      tck_m_r <= tck;
      tck_s_r <= tck_m_r;
      tck_d_r <= tck_s_r;
      tms_m_r <= tms;
      tms_s_r <= tms_m_r;
      tdi_m_r <= tdi;
      tdi_s_r <= tdi_m_r;
      trst_m_r <= trst_n;
      trst_s_r <= trst_m_r;
      pad_m_r <= pad_in;
      pad_s_r <= pad_m_r;
    end
  end

  // tck edges found on the synchronised copy; tms and tdi share its delay
  assign tck_rise = tck_s_r & ~tck_d_r;
  assign tck_fall = ~tck_s_r & tck_d_r;

  // core inputs see the pins unchanged; the cells only observe them
  // so sample and extest never cut the fifo off from its inputs
  assign core_in = pad_s_r;

  // tap state register
  always @* begin
    state_nxt = state_r;
    if (tck_rise) begin
      state_nxt = tap_next(state_r, tms_s_r);
    end
  end

  // rst_n stands for board reset; power-up with no rst_n has no own reset
  // a low trst_n parks the state in reset whatever tms does
  always @(posedge clock) begin
    if (!rst_n) begin
      state_r <= `ST_RESET;
    end else if (!trst_s_r) begin
      state_r <= `ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // instruction shifter: capture, shift, hold in pause
  // exit states hold as well, so a pause never loses bits
  always @(posedge clock) begin
    if (!rst_n) begin
      ir_shift_r <= `IR_CAPTURE;
    end else if (tck_rise) begin
      case (state_r)
        `ST_CAP_IR: ir_shift_r <= `IR_CAPTURE;
        `ST_SHIFT_IR: ir_shift_r <= {tdi_s_r, ir_shift_r[`IR_W-1:1]};
        `ST_PAUSE_IR: ir_shift_r <= ir_shift_r;
        default: ir_shift_r <= ir_shift_r;
      endcase
    end
  end

  // instruction latch, written on the falling tck in update-ir
  // a scan in progress never changes what the pads see
  always @(posedge clock) begin
    if (!rst_n) begin
      active_instruction <= `OP_IDCODE;
    end else if (!trst_s_r || state_r == `ST_RESET) begin
      active_instruction <= `OP_IDCODE;
    end else if (tck_fall && state_r == `ST_UPD_IR) begin
      active_instruction <= ir_shift_r;
    end
  end

  // data register picked by the latched instruction
  assign dr_sel = dr_decode(active_instruction);

  // identification word, fixed wiring so it cannot be written
  assign id_word = {ID_VERSION, ID_PART, ID_MFR, `ID_MARK};

  // bypass stage: zero on capture, one-bit path on shift
  // it holds its bit in every other state
  always @(posedge clock) begin
    if (!rst_n) begin
      bypass_r <= 1'b0;
    end else if (tck_rise && dr_sel == `SEL_BYPASS) begin
      if (state_r == `ST_CAP_DR) begin
        bypass_r <= 1'b0;
      end else if (state_r == `ST_SHIFT_DR) begin
        bypass_r <= tdi_s_r;
      end
    end
  end

  // identification shifter, reloaded from the constant word on capture
  // bits shifted in are thrown away at the next capture
  always @(posedge clock) begin
    if (!rst_n) begin
      id_shift_r <= {`ID_W{1'b0}};
    end else if (tck_rise && dr_sel == `SEL_IDENT) begin
      if (state_r == `ST_CAP_DR) begin
        id_shift_r <= id_word;
      end else if (state_r == `ST_SHIFT_DR) begin
        id_shift_r <= {tdi_s_r, id_shift_r[`ID_W-1:1]};
      end
    end
  end

  // boundary chain controls; update on the falling tck like the ir
  assign bsr_capture = tck_rise && state_r == `ST_CAP_DR && dr_sel == `SEL_BOUNDARY;
  assign bsr_shift = tck_rise && state_r == `ST_SHIFT_DR && dr_sel == `SEL_BOUNDARY;
  assign bsr_update = tck_fall && state_r == `ST_UPD_DR && dr_sel == `SEL_BOUNDARY;
  // cells capture pins in and the functional value headed out
  assign bsr_par = {core_out, pad_s_r};

  boundary_chain u_chain (
    .clock(clock),
    .rst_n(rst_n),
    .capture(bsr_capture),
    .shift(bsr_shift),
    .update(bsr_update),
    .serial_in(tdi_s_r),
    .parallel_in(bsr_par),
    .serial_out(bsr_so),
    .update_r(bsr_upd)
  );

  // output cells take the pads only under extest; highz only turns the drivers off
  assign drive_test = active_instruction == `OP_EXTEST;
  assign force_off = active_instruction == `OP_HIGHZ;

  // pad drivers registered; test modes override the fifo
  // registered so a change of instruction cannot glitch a pad
  always @(posedge clock) begin
    if (!rst_n) begin
      pad_out <= {`N_PAD_OUT{1'b0}};
      pad_oe <= {`N_PAD_OUT{1'b0}};
      fifo_hold <= 1'b0;
    end else if (state_r == `ST_RESET) begin
      pad_out <= core_out;
      pad_oe <= {`N_PAD_OUT{core_oe}};
      fifo_hold <= 1'b0;
    end else if (force_off) begin
      pad_out <= core_out;
      pad_oe <= {`N_PAD_OUT{1'b0}};
      fifo_hold <= 1'b1;
    end else if (drive_test) begin
      pad_out <= bsr_upd[`BSR_LEN-1:`N_PAD_IN];
      pad_oe <= {`N_PAD_OUT{1'b1}};
      fifo_hold <= 1'b1;
    end else begin
      // sample, idcode and bypass leave the device alone
      pad_out <= core_out;
      pad_oe <= {`N_PAD_OUT{core_oe}};
      fifo_hold <= 1'b0;
    end
  end

  // reset-state flag lets the fifo know the tap is out of its way
  // one clock behind the state, in step with the pads
  always @(posedge clock) begin
    if (!rst_n) begin
      tap_in_reset <= 1'b1;
    end else begin
      tap_in_reset <= state_r == `ST_RESET;
    end
  end

  // serial output source for the current shift state
  // bypass also serves highz and every unknown code
  always @* begin
    tdo_nxt = 1'b0;
    if (state_r == `ST_SHIFT_IR) begin
      tdo_nxt = ir_shift_r[0];
    end else begin
      case (dr_sel)
        `SEL_IDENT: tdo_nxt = id_shift_r[0];
        `SEL_BOUNDARY: tdo_nxt = bsr_so;
        default: tdo_nxt = bypass_r;
      endcase
    end
  end

  // tdo changes on falling tck so the controller samples it stable
  // the reset state silences tdo at once, without waiting for tck
  always @(posedge clock) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (state_r == `ST_RESET) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      if (state_r == `ST_SHIFT_IR || state_r == `ST_SHIFT_DR) begin
        tdo <= tdo_nxt;
        tdo_oe <= 1'b1;
      end else begin
        tdo <= 1'b0;
        tdo_oe <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- testbench/tap_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// outside test controller; tck parks low between frames
module tap_ctrl_model (
  input wire logic clock,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // one tck period: 4 clocks low, 4 high; tdo taken at the rise
  task step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clock);
    tck = 1'b1;
    q = tdo;
    repeat (4) @(negedge clock);
    tck = 1'b0;
  endtask

  // tdi toggles when unused so a stale level never looks valid
  task nav(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask

  // five rises with tms high, then on to idle
  task tms_reset;
    repeat (5) nav(1'b1);
    nav(1'b0);
  endtask

  task pulse_trst;
    trst_n = 1'b0;
    repeat (5) @(negedge clock);
    trst_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask

  // idle to idle scan, lsb first in and out
  task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    nav(1'b1);
    if (ir)
      nav(1'b1);
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    nav(1'b1);
    nav(1'b0);
  endtask
endmodule
`default_nettype wire

// ---- testbench/tap_checker_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tap_defs.vh"
module tap_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [`N_PAD_OUT-1:0] core_out,
  input wire logic core_oe,
  input wire logic [`N_PAD_OUT-1:0] pad_out,
  input wire logic [`N_PAD_OUT-1:0] pad_oe,
  input wire logic fifo_hold,
  input wire logic tap_in_reset,
  input wire logic [`IR_W-1:0] active_instruction
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // quiet spans long enough to drain the pin synchronisers
  sequence s_tck_low; (!tck && trst_n)[*8]; endsequence
  sequence s_tck_high; (tck && trst_n)[*2]; endsequence
  sequence s_trst_low; (!trst_n)[*4]; endsequence
  sequence s_in_reset; tap_in_reset && $past(tap_in_reset) && $past(rst_n); endsequence

  property p_trst; s_trst_low |-> ##[0:4] tap_in_reset; endproperty
  a_trst: assert property (p_trst) else $error("trst did not reset tap");
  property p_state_quiet; s_tck_low |-> $stable(tap_in_reset) && $stable(active_instruction); endproperty
  a_state_quiet: assert property (p_state_quiet) else $error("state moved without tck");
  property p_tdo_quiet; s_tck_high |-> $stable(tdo) && $stable(tdo_oe); endproperty
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("tdo moved while tck high");
  property p_oe_reset; tdo_oe |-> !tap_in_reset; endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("tdo driven in reset state");
  property p_pads; s_in_reset |-> pad_out == $past(core_out) && pad_oe == {`N_PAD_OUT{$past(core_oe)}} && !fifo_hold;
  endproperty
  a_pads: assert property (p_pads) else $error("pads not with fifo in reset");
  property p_id_reset; s_in_reset |-> active_instruction == `OP_IDCODE; endproperty
  a_id_reset: assert property (p_id_reset) else $error("reset did not select idcode");
  property p_highz; (active_instruction == `OP_HIGHZ)[*3] |-> fifo_hold && pad_oe == 0; endproperty
  a_highz: assert property (p_highz) else $error("highz left outputs on");
  property p_free;
    (active_instruction != `OP_EXTEST && active_instruction != `OP_HIGHZ)[*3] |-> !fifo_hold;
  endproperty
  a_free: assert property (p_free) else $error("fifo held outside extest");
  property p_extest; (active_instruction == `OP_EXTEST && !tap_in_reset)[*3] |-> fifo_hold; endproperty
  a_extest: assert property (p_extest) else $error("extest did not take pins");
endmodule

bind boundary_scan_tap tap_checker u_chk (.clock(clock), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tdo(tdo),
  .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
  .fifo_hold(fifo_hold), .tap_in_reset(tap_in_reset), .active_instruction(active_instruction));
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tap_defs.vh"
module tb;
  logic clock, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, core_oe, fifo_hold, tap_in_reset;
  logic [7:0] pad_in, core_in, core_out, pad_out, pad_oe;
  logic [3:0] active_instruction;
  logic [31:0] got;
  int err_count = 0;
  int checks_done = 0;
  // identity fields are arbitrary
  localparam logic [31:0] ID_WORD = {4'h3, 16'hC0DE, 11'h155, 1'h1};
  localparam logic [23:0] CODES = {4'hF, 4'h5, 4'h3, 4'h2, 4'h1, 4'h0};

  boundary_scan_tap #(.ID_VERSION(4'h3), .ID_PART(16'hC0DE), .ID_MFR(11'h155)) dut (.clock(clock),
    .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .pad_in(pad_in), .core_in(core_in), .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out),
    .pad_oe(pad_oe), .fifo_hold(fifo_hold), .tap_in_reset(tap_in_reset), .active_instruction(active_instruction));
  tap_ctrl_model p (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wrap_up;
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task t_idcode;
    p.tms_reset();
    p.scan(1'b0, 32, 32'h0, got);
    chk(got, ID_WORD);
    $display("test idcode done");
  endtask

  // every defined code; unknown 5 must act as bypass; the fifo side moves per code
  task t_codes;
    logic hold;
    logic [3:0] code;
    for (int i = 0; i < 6; i++) begin
      code = CODES[i*4 +: 4];
      core_out = {4'h3, code};
      core_oe = ~core_oe;
      pad_in = ~core_out;
      p.scan(1'b1, 4, {28'h0, code}, got);
      chk(got, 32'h1);
      chk(active_instruction, code);
      hold = (code == `OP_EXTEST) || (code == `OP_HIGHZ);
      chk(fifo_hold, hold);
      chk(core_in, pad_in);
      if (code == `OP_HIGHZ)
        chk(pad_oe, 8'h0);
      else if (hold)
        chk(pad_oe, 8'hFF);
      else begin
        chk(pad_out, core_out);
        chk(pad_oe, {8{core_oe}});
      end
      if (code > 4'h3) begin
        p.scan(1'b0, 8, 32'hB4, got);
        chk(got, 32'h68);
      end
    end
    $display("test codes done");
  endtask

  // preload under sample, then drive and capture under extest
  task t_boundary;
    pad_in = 8'hA5;
    p.scan(1'b1, 4, 32'h1, got);
    p.scan(1'b0, 16, 32'h5A00, got);
    chk(got[7:0], 8'hA5);
    chk(core_in, 8'hA5);
    p.scan(1'b1, 4, 32'h0, got);
    chk(pad_out, 8'h5A);
    pad_in = 8'h3C;
    p.scan(1'b0, 16, 32'h5A00, got);
    chk(got[7:0], 8'h3C);
    chk(pad_out, 8'h5A);
    $display("test boundary done");
  endtask

  task t_trst;
    p.pulse_trst();
    chk(tap_in_reset, 1'b1);
    chk(active_instruction, `OP_IDCODE);
    chk(fifo_hold, 1'b0);
    chk(tdo_oe, 1'b0);
    chk(pad_out, core_out);
    p.nav(1'b0);
    $display("test trst done");
  endtask

  // from shift-dr, four ones must not reach reset, the fifth must
  task t_deep_reset;
    p.scan(1'b1, 4, 32'hF, got);
    p.nav(1'b1);
    p.nav(1'b0);
    p.nav(1'b0);
    repeat (4) p.nav(1'b1);
    repeat (4) @(negedge clock);
    chk(tap_in_reset, 1'b0);
    p.nav(1'b1);
    repeat (4) @(negedge clock);
    chk(tap_in_reset, 1'b1);
    chk(active_instruction, `OP_IDCODE);
    $display("test deep reset done");
  endtask

  initial begin
    rst_n = 1'b0;
    pad_in = 8'hA5;
    core_out = 8'h3C;
    core_oe = 1'b1;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    t_idcode();
    t_codes();
    t_boundary();
    t_trst();
    t_deep_reset();
    wrap_up();
  end

  // about 210 tck periods of 80 ns expected; allow about six times that
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
